// ==== tb/smb_host.sv ====
// behavioural two-wire host that drives the bus clock and its side of the data line
`timescale 1ns/1ps
module smb_host (
  input wire logic clk, // bench clock
  output logic scl, // bus clock level
  output logic sda_oe, // high pulls data low
  input wire logic sda // resolved data wire
);
  // ----
  // bus phases
  // ----
  // one bit is 25 bench cycles (125 ns); data bits move only mid-low, never near a clock edge; start and stop move data mid-high
  initial begin
    scl = 1'b1;
    sda_oe = 1'b0;
  end
  task automatic w(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic clk_bit(input logic b, output logic s);
    scl <= 1'b0;
    w(6);
    sda_oe <= ~b;
    w(7);
    scl <= 1'b1;
    w(6);
    s = sda;
    w(6);
  endtask
  task automatic start();
    logic s;
    clk_bit(1'b1, s);
    sda_oe <= 1'b1;
    w(12);
  endtask
  task automatic stop();
    logic s;
    clk_bit(1'b0, s);
    sda_oe <= 1'b0;
    w(12);
  endtask
  task automatic hold_low(input int n);
    scl <= 1'b0; // stretching by the host
    w(n);
  endtask
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) clk_bit(d[i], s);
    clk_bit(1'b1, s);
    ack = ~s;
  endtask
  task automatic rbyte(input logic ack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(1'b1, s);
      d[i] = s;
    end
    clk_bit(~ack, s);
  endtask
endmodule

// ==== tb/touch_sensor_smbus_slave_test.sv ====
// self-checking bench for the two-wire slave port against a host model
`timescale 1ns/1ps
module touch_sensor_smbus_slave_test;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic timeout_en = 1'b0;
  logic deep_sleep = 1'b0;
  logic scl, host_oe, sda_oe, sda_o, awake, ready, reg_rd, reg_wr, ack;
  logic [7:0] reg_index, reg_wdata, reg_rdata, got;
  logic [7:0] regs [256];
  logic [15:0] wq [$];
  int err_count = 0;
  int n_checks = 0;
  int cycles = 0;
  int n_reads = 0;
  int exp_reads = 0;
  int seed = 32'h2f2e07a1;
  wire sda = ~(sda_oe | host_oe);
  assign reg_rdata = regs[reg_index];
  always #2.5 clock = ~clock;

  touch_sensor_smbus_slave #(.QUIET_CYCLES(20), .TOUT_CYCLES(2000), .IDLE_CYCLES(400))
    i_touch_sensor_smbus_slave (.CLOCK(clock), .RST(rst), .SCL_I(scl), .SDA_I(sda),
    .SDA_O(sda_o), .SDA_OE(sda_oe), .TIMEOUT_EN(timeout_en), .DEEP_SLEEP_FLAG(deep_sleep),
    .AWAKE(awake), .READY(ready), .REG_INDEX(reg_index), .REG_RDATA(reg_rdata),
    .REG_RD(reg_rd), .REG_WDATA(reg_wdata), .REG_WR(reg_wr));
  smb_host i_smb_host (.clk(clock), .scl(scl), .sda_oe(host_oe), .sda(sda));

  // ----
  // checking
  // ----
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic check(input logic [15:0] g, input logic [15:0] e, input string msg);
    n_checks++;
    if (g !== e) begin
      err_count++;
      $display("unexpected at %0t: %s got %h expected %h", $time, msg, g, e);
    end
  endtask
  // writes are only ever expected in order, so any extra pulse is caught here
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (reg_rd === 1'b1) n_reads <= n_reads + 1;
    if (reg_wr === 1'b1) begin
      regs[reg_index] <= reg_wdata;
      if (wq.size() == 0) check({reg_index, reg_wdata}, 16'hxxxx, "stray write");
      else check({reg_index, reg_wdata}, wq.pop_front(), "register write");
    end
    if (cycles == 40000) begin
      err_count++;
      final_report();
    end
  end
  task automatic wr(input logic [7:0] d, input logic e, input string msg);
    i_smb_host.wbyte(d, ack);
    check(16'(ack), 16'(e), msg);
  endtask
  task automatic rd(input logic a, input logic [7:0] e, input string msg);
    exp_reads++;
    i_smb_host.rbyte(a, got);
    check(16'(got), 16'(e), msg);
  endtask
  task automatic index_read(input logic [7:0] idx);
    i_smb_host.start();
    wr(8'h50, 1'b1, "addr ack");
    wr(idx, 1'b1, "index ack");
    i_smb_host.start();
    wr(8'h51, 1'b1, "read addr ack");
  endtask

  // ----
  // scenarios
  // ----
  initial begin
    logic [7:0] idx;
    logic [7:0] d [3];
    logic [7:0] bad [3] = '{8'h52, 8'h29, 8'hd1};
    for (int i = 0; i < 256; i++) regs[i] = 8'($random(seed));
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    check(16'(ready), 16'h0, "ready early");
    repeat (30) @(posedge clock);
    check(16'(ready), 16'h1, "ready late");
    idx = 8'($random(seed));
    d[0] = 8'($random(seed));
    wq.push_back({idx, d[0]});
    i_smb_host.start();
    wr(8'h50, 1'b1, "addr ack");
    wr(idx, 1'b1, "index ack");
    wr(d[0], 1'b1, "data ack");
    i_smb_host.stop();
    index_read(idx);
    rd(1'b0, d[0], "read byte");
    i_smb_host.stop();
    $display("test single byte done");
    i_smb_host.start();
    wr(8'h50, 1'b1, "addr ack");
    wr(8'hfe, 1'b1, "index ack");
    for (int i = 0; i < 3; i++) begin
      d[i] = 8'($random(seed));
      wq.push_back({8'hfe + 8'(i), d[i]});
      wr(d[i], 1'b1, "block data ack");
    end
    i_smb_host.stop();
    index_read(8'hfe);
    for (int i = 0; i < 3; i++) rd(i < 2, d[i], "block read");
    i_smb_host.stop();
    check(16'(reg_index), 16'h0, "pointer wrap");
    $display("test block done");
    deep_sleep <= 1'b1;
    idx = 8'($random(seed));
    i_smb_host.start();
    wr(8'h50, 1'b1, "addr ack");
    wr(idx, 1'b1, "send byte ack");
    i_smb_host.stop();
    check(16'(reg_index), 16'(idx), "pointer loaded");
    repeat (2) begin
      i_smb_host.start();
      wr(8'h51, 1'b1, "recv addr ack");
      check(16'(awake), 16'h1, "awake in traffic");
      rd(1'b0, regs[idx], "receive byte");
      i_smb_host.stop();
    end
    check(16'(awake), 16'h0, "awake after stop");
    deep_sleep <= 1'b0;
    $display("test pointer forms done");
    foreach (bad[i]) begin
      i_smb_host.start();
      wr(bad[i], 1'b0, "foreign addr");
      wr(8'h00, 1'b0, "ignored byte");
      i_smb_host.stop();
    end
    $display("test foreign address done");
    for (int en = 0; en < 2; en++) begin
      timeout_en <= en[0];
      i_smb_host.start();
      wr(8'h50, 1'b1, "addr ack");
      i_smb_host.hold_low(2100);
      wr(8'h33, !en[0], "after long low");
      i_smb_host.stop();
      i_smb_host.start();
      wr(8'h50, 1'b1, "addr ack");
      for (int i = 0; i < 9; i++) begin
        i_smb_host.clk_bit(1'b1, ack);
        if (i == 0) i_smb_host.w(450);
      end
      check(16'(!ack), 16'(!en[0]), "after long idle");
      i_smb_host.stop();
    end
    timeout_en <= 1'b0;
    $display("test timeout done");
    check(16'(wq.size()), 16'h0, "writes pending");
    check(16'(n_reads), 16'(exp_reads), "read strobes");
    check(16'(sda_o), 16'h0, "data drive level");
    final_report();
  end
endmodule

// ==== verilog/smb_defs.svh ====
// constants of the two-wire slave port: address, timing and reset values
`ifndef SMB_DEFS_SVH
`define SMB_DEFS_SVH
`define SLV_ADDR 7'h28
`define PTR_RST 8'h00
`define BYTE_BITS 4'h8
`define CNT_W 23
`define CLK_MHZ 200
`define QUIET_MS 15
`define TOUT_MS 30
`define IDLE_US 200
`define QUIET_CYC (`QUIET_MS * 1000 * `CLK_MHZ)
`define TOUT_CYC (`TOUT_MS * 1000 * `CLK_MHZ)
`define IDLE_CYC (`IDLE_US * `CLK_MHZ)
`endif

// ==== verilog/smb_pkg.sv ====
// types of the two-wire slave port
package smb_pkg;
  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_WR_BYTE, ST_WR_ACK, ST_RD_BYTE, ST_RD_ACK, ST_IGNORE
  } state_t;
endpackage

// ==== verilog/sync2.sv ====
// two-flop synchroniser for one pin level
`timescale 1ns/1ps
module sync2 (
  input wire logic clk, // sampling clock
  input wire logic rst, // synchronous reset, high
  input wire logic rst_val, // level after reset
  input wire logic async_in, // pin level
  output logic sync_out // level in clk domain
);
  logic meta_q;
  logic meta_d;
  logic sync_d;

  always_comb begin
    meta_d = async_in;
    sync_d = meta_q;
  end

  // reset value is a port so idle-high pins are not seen as falling edges
  always_ff @(posedge clk) begin
    if (rst) begin
      meta_q <= rst_val;
      sync_out <= rst_val;
    end else begin
      meta_q <= meta_d;
      sync_out <= sync_d;
    end
  end
endmodule

// ==== verilog/touch_sensor_smbus_slave.sv ====
// two-wire slave port: address match, byte transfers, register pointer, timeouts
`timescale 1ns/1ps
`include "smb_defs.svh"

// What this block does
// - start: data falls while clock high
// - stop: data rises while clock high
// - first byte: seven address bits, direction
// - direction 0 writes, 1 reads
// - answer only address 0101_000
// - eight bits per byte, msb first
// - acknowledge every received byte
// - stop returns slave to idle
// - enabled clock-low 30ms timeout resets interface
// - timeout off until enable set
// - enabled 200us both-high idle resets
// - never stretch clock; tolerate host stretching
// - clock 10kHz to 400kHz supported
// - block transfers: no count byte, unlimited
// - write: address, index, data, stop
// - read: index write, restart, one byte
// - index-only write loads pointer only
// - direct read uses current pointer
// - pointer-only forms optional in deep sleep
// - may ignore bus 15ms after reset
// - pointer increments per written or acked read byte, wraps
// - addressed traffic wakes, flag kept
module touch_sensor_smbus_slave import smb_pkg::*; #(
  parameter int unsigned QUIET_CYCLES = `QUIET_CYC, // power-up quiet period
  parameter int unsigned TOUT_CYCLES = `TOUT_CYC, // clock-low timeout
  parameter int unsigned IDLE_CYCLES = `IDLE_CYC // both-high idle reset
) (
  input wire logic CLOCK, // 200 MHz system clock
  input wire logic RST, // synchronous reset, high
  input wire logic SCL_I, // serial_clock_pin level
  input wire logic SDA_I, // serial_data_pin level
  output logic SDA_O, // serial_data_pin drive value, always low
  output logic SDA_OE, // high pulls serial_data_pin low
  input wire logic TIMEOUT_EN, // enables clock-low and idle resets
  input wire logic DEEP_SLEEP_FLAG, // deep_sleep_flag from power logic
  output logic AWAKE, // addressed traffic in progress
  output logic READY, // quiet period over
  output logic [7:0] REG_INDEX, // register pointer
  input wire logic [7:0] REG_RDATA, // data of register at REG_INDEX
  output logic REG_RD, // pulse: REG_RDATA taken
  output logic [7:0] REG_WDATA, // write data
  output logic REG_WR // pulse: write REG_WDATA at REG_INDEX
);
  // ----------------------------------------------------------------
  // pin sampling and bus conditions
  // ----------------------------------------------------------------
  logic scl_s;
  logic sda_s;
  logic scl_p_q;
  logic sda_p_q;
  logic start_c;
  logic stop_c;
  logic rise_c;
  logic fall_c;

  sync2 u_scl_sync (
    .clk(CLOCK),
    .rst(RST),
    .rst_val(1'b1),
    .async_in(SCL_I),
    .sync_out(scl_s)
  );
  sync2 u_sda_sync (
    .clk(CLOCK),
    .rst(RST),
    .rst_val(1'b1),
    .async_in(SDA_I),
    .sync_out(sda_s)
  );

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      scl_p_q <= scl_s;
      sda_p_q <= sda_s;
    end
  end

  // oversampling at 200 MHz covers any host rate and any stretched low phase
  always_comb begin
    start_c = scl_s && scl_p_q && sda_p_q && !sda_s;
    stop_c = scl_s && scl_p_q && !sda_p_q && sda_s;
    rise_c = scl_s && !scl_p_q;
    fall_c = !scl_s && scl_p_q;
  end

  // ----------------------------------------------------------------
  // quiet period and bus timers
  // ----------------------------------------------------------------
  logic [`CNT_W-1:0] quiet_q, quiet_d;
  logic [`CNT_W-1:0] low_q, low_d;
  logic [`CNT_W-1:0] hi_q, hi_d;
  logic ready_q, ready_d;
  logic tout_c;

  always_comb begin
    ready_d = ready_q || (quiet_q >= `CNT_W'(QUIET_CYCLES - 1));
    quiet_d = ready_q ? quiet_q : quiet_q + `CNT_W'(1);
    low_d = scl_s ? '0 : (low_q == '1 ? low_q : low_q + `CNT_W'(1));
    hi_d = (scl_s && sda_s) ? (hi_q == '1 ? hi_q : hi_q + `CNT_W'(1)) : '0;
    tout_c = TIMEOUT_EN && ((low_q >= `CNT_W'(TOUT_CYCLES))
                            || (scl_s && sda_s && hi_q >= `CNT_W'(IDLE_CYCLES)));
  end

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      quiet_q <= '0;
      low_q <= '0;
      hi_q <= '0;
      ready_q <= 1'b0;
    end else begin
      quiet_q <= quiet_d;
      low_q <= low_d;
      hi_q <= hi_d;
      ready_q <= ready_d;
    end
  end

  // ----------------------------------------------------------------
  // slave state machine
  // ----------------------------------------------------------------
  state_t state_q, state_d;
  logic [3:0] cnt_q, cnt_d;
  logic [7:0] shift_q, shift_d;
  logic [7:0] tx_q, tx_d;
  logic [7:0] ptr_q, ptr_d;
  logic [7:0] wdata_q, wdata_d;
  logic oe_q, oe_d;
  logic idx_q, idx_d;
  logic wrote_q, wrote_d;
  logic nack_q, nack_d;
  logic wr_q, wr_d;
  logic rd_q, rd_d;
  logic awake_q, awake_d;
  logic byte_c;

  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    shift_d = shift_q;
    tx_d = tx_q;
    ptr_d = ptr_q;
    wdata_d = wdata_q;
    oe_d = oe_q;
    idx_d = idx_q;
    wrote_d = wrote_q;
    nack_d = nack_q;
    wr_d = 1'b0;
    rd_d = 1'b0;
    byte_c = (cnt_q == `BYTE_BITS);
    if (!ready_q || tout_c) begin
      state_d = ST_IDLE;
      oe_d = 1'b0;
    end else if (start_c) begin
      state_d = ST_ADDR;
      cnt_d = '0;
      oe_d = 1'b0;
    end else if (stop_c) begin
      state_d = ST_IDLE;
      oe_d = 1'b0;
    end else begin
      unique case (state_q)
        ST_IDLE, ST_IGNORE: oe_d = 1'b0;
        ST_ADDR, ST_WR_BYTE: begin
          if (rise_c && !byte_c) begin
            shift_d = {shift_q[6:0], sda_s};
            cnt_d = cnt_q + 4'h1;
          end else if (fall_c && byte_c) begin
            cnt_d = '0;
            if (state_q == ST_ADDR) begin
              if (shift_q[7:1] == `SLV_ADDR) begin
                state_d = ST_ADDR_ACK;
                oe_d = 1'b1;
              end else begin
                state_d = ST_IGNORE;
              end
            end else begin
              state_d = ST_WR_ACK;
              oe_d = 1'b1;
              wrote_d = !idx_q;
              if (idx_q) begin
                ptr_d = shift_q;
                idx_d = 1'b0;
              end else begin
                wdata_d = shift_q;
                wr_d = 1'b1;
              end
            end
          end
        end
        ST_ADDR_ACK: begin
          if (fall_c) begin
            if (shift_q[0]) begin
              // pointer reads are served in deep sleep as well
              state_d = ST_RD_BYTE;
              tx_d = REG_RDATA;
              oe_d = !REG_RDATA[7];
              rd_d = 1'b1;
            end else begin
              state_d = ST_WR_BYTE;
              oe_d = 1'b0;
              idx_d = 1'b1;
            end
          end
        end
        ST_WR_ACK: begin
          if (fall_c) begin
            state_d = ST_WR_BYTE;
            oe_d = 1'b0;
            if (wrote_q) begin
              ptr_d = ptr_q + 8'h01;
            end
          end
        end
        ST_RD_BYTE: begin
          if (rise_c && !byte_c) begin
            cnt_d = cnt_q + 4'h1;
          end else if (fall_c) begin
            if (byte_c) begin
              state_d = ST_RD_ACK;
              oe_d = 1'b0;
              cnt_d = '0;
            end else begin
              tx_d = {tx_q[6:0], 1'b0};
              oe_d = !tx_q[6];
            end
          end
        end
        ST_RD_ACK: begin
          if (rise_c) begin
            nack_d = sda_s;
            if (!sda_s) begin
              // only an acked byte moves on, so single reads repeat one register
              ptr_d = ptr_q + 8'h01;
            end
          end else if (fall_c) begin
            if (nack_q) begin
              state_d = ST_IGNORE;
            end else begin
              state_d = ST_RD_BYTE;
              tx_d = REG_RDATA;
              oe_d = !REG_RDATA[7];
              rd_d = 1'b1;
            end
          end
        end
      endcase
    end
    // deep sleep is left to the power logic; busy only marks the wake request
    awake_d = (state_d != ST_IDLE) && (state_d != ST_IGNORE) && (state_d != ST_ADDR);
  end

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      state_q <= ST_IDLE;
      cnt_q <= '0;
      shift_q <= 8'h00;
      tx_q <= 8'h00;
      ptr_q <= `PTR_RST;
      wdata_q <= 8'h00;
      oe_q <= 1'b0;
      idx_q <= 1'b0;
      wrote_q <= 1'b0;
      nack_q <= 1'b0;
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      awake_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      shift_q <= shift_d;
      tx_q <= tx_d;
      ptr_q <= ptr_d;
      wdata_q <= wdata_d;
      oe_q <= oe_d;
      idx_q <= idx_d;
      wrote_q <= wrote_d;
      nack_q <= nack_d;
      wr_q <= wr_d;
      rd_q <= rd_d;
      awake_q <= awake_d;
    end
  end

  // the clock pin has no driver at all, so stretching cannot happen
  always_comb begin
    SDA_O = 1'b0;
    SDA_OE = oe_q;
    AWAKE = awake_q;
    READY = ready_q;
    REG_INDEX = ptr_q;
    REG_WDATA = wdata_q;
    REG_WR = wr_q;
    REG_RD = rd_q;
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (RST);

  a_start_addr: assert property (start_c && ready_q |=> state_q == ST_ADDR)
    else $error("start did not open address phase");
  a_stop_idle: assert property (stop_c && ready_q |=> state_q == ST_IDLE && !SDA_OE)
    else $error("stop did not return to idle");
  a_quiet_deaf: assert property (!ready_q |=> state_q == ST_IDLE && !SDA_OE)
    else $error("bus answered during quiet period");
  a_bad_addr: assert property (state_q == ST_ADDR && fall_c && byte_c && !start_c && !stop_c
      && !tout_c && shift_q[7:1] != `SLV_ADDR |=> state_q == ST_IGNORE ##1 !SDA_OE)
    else $error("foreign address not ignored");
  a_ack_write: assert property (REG_WR |-> SDA_OE && state_q == ST_WR_ACK)
    else $error("write without acknowledge");
  a_index_only: assert property (state_q == ST_WR_BYTE && idx_q && fall_c && byte_c
      && ready_q && !tout_c && !start_c && !stop_c
      |=> REG_INDEX == $past(shift_q) && !REG_WR)
    else $error("index byte not loaded alone");
  a_ptr_wrap: assert property (state_q == ST_WR_ACK && wrote_q && fall_c && ready_q
      && !tout_c && !start_c && !stop_c |=> REG_INDEX == $past(REG_INDEX) + 8'h01)
    else $error("pointer did not advance");
  a_read_msb: assert property (state_q == ST_ADDR_ACK && shift_q[0] && fall_c && ready_q
      && !tout_c && !start_c && !stop_c |=> REG_RD && SDA_OE == !$past(REG_RDATA[7]))
    else $error("read byte msb not driven first");
  a_timeout_off: assert property (!TIMEOUT_EN && ready_q && state_q == ST_WR_BYTE && !scl_s
      && low_q >= `CNT_W'(TOUT_CYCLES) |=> state_q == ST_WR_BYTE)
    else $error("timeout acted while disabled");
  a_timeout_hit: assert property (tout_c && ready_q && !scl_s |=> state_q == ST_IDLE [*2])
    else $error("timeout did not reset interface");
  a_idle_reset: assert property (TIMEOUT_EN && ready_q && scl_s && sda_s
      && hi_q >= `CNT_W'(IDLE_CYCLES) |=> state_q == ST_IDLE && !SDA_OE)
    else $error("idle bus did not reset interface");

  c_write: cover property (REG_WR);
  c_read_more: cover property (state_q == ST_RD_ACK && fall_c && !nack_q);
  c_read_nack: cover property (state_q == ST_RD_ACK ##1 state_q == ST_IGNORE);
  c_timeout: cover property (tout_c && state_q != ST_IDLE);
endmodule
